// >>> irqv_top.sv
// vme interrupt handler vector fetch, end-of-interrupt latch and on-board interrupter
//
// Operation
// - vector read returns serviced source's vector
// - bus interrupt served before local done
// - vector read runs bus iack cycle only when a bus source is served
// - any byte write to eoi triggers it
// - eoi clears latch, rearms host edge
// - level code selects irq3 to irq7
// - level register unchanged by iack
// - level register read/write, reset undefined
// - flag bit stored and read back
// - line state reads seven irq levels
// - line state keeps active-low bus polarity
// - write-only byte holds outgoing status/id
// - interrupter releases line on acknowledge
// - acknowledge raises done when enabled
// - done reaches nmi only when enabled
// - highest numbered enabled irq first
`timescale 1ns/1ns
module irqv_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_READY,
  input wire logic [6:0] IRQ_MASK,
  input wire logic [7:0] GROUP_MASK,
  input wire logic [7:0] DONE_VECTOR,
  input wire logic DONE_PENDING,
  input wire logic LOCAL_REQUEST,
  input wire logic [6:0] VME_IRQ_N,
  output logic [6:0] VME_IRQ_OE,
  output logic HOST_IRQ,
  output logic HOST_NMI_DONE,
  output logic VME_IACK_REQ,
  output logic [2:0] VME_IACK_LEVEL,
  input wire logic VME_IACK_DONE,
  input wire logic [7:0] VME_IACK_DATA,
  input wire logic EXT_IACK_SEL,
  input wire logic EXT_IACK_READ,
  output logic [7:0] EXT_IACK_DATA
);
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    IACK = 3'b010,
    ANSWER = 3'b100
  } fetch_e;

  fetch_e state;
  fetch_e next_state;
  logic [6:0] irq_level;
  logic [7:0] level_reg;
  logic [7:0] out_vector;
  logic [7:0] read_data;
  logic [7:0] fetched;
  logic latched;
  logic latched_vme;
  logic [2:0] latched_level;
  logic requesting;
  logic done_event;
  logic rd_vec_d;
  logic level_known;

  irqv_sync u_sync (
    .clk(CLK),
    .reset(RESET),
    .async_in(VME_IRQ_N),
    .stable(irq_level)
  );

  irqv_level_decode u_dec (
    .level_code(level_reg[irqv_pkg::LEVEL_MSB:0]),
    .request(requesting),
    .line_drive(VME_IRQ_OE)
  );

  // active-low lines; gated by individual and group masks
  wire [6:0] vme_active = ~irq_level & IRQ_MASK & {7{GROUP_MASK[irqv_pkg::VME_ENABLE_POS]}};
  wire vme_any = |vme_active;
  // an acknowledged on-board interrupt stays a done source until eoi
  wire done_ok = (DONE_PENDING || done_event) && GROUP_MASK[irqv_pkg::DONE_ENABLE_POS];

  function automatic logic [2:0] top_level(input logic [6:0] act);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (act[i]) begin
        r = 3'(i + 1);
      end
    end
    return r;
  endfunction : top_level

  wire [2:0] vme_level = top_level(vme_active);
  wire hit_vec = IO_ADDR == irqv_pkg::VECTOR_OFFSET;
  wire hit_lvl = IO_ADDR == irqv_pkg::LEVEL_OFFSET;
  wire hit_line = IO_ADDR == irqv_pkg::LINE_STATE_OFFSET;
  wire rd_vec = IO_RD && hit_vec;
  wire rd_vec_start = rd_vec && !rd_vec_d;
  wire wr_eoi = IO_WR && (IO_ADDR == irqv_pkg::EOI_OFFSET);
  wire wr_lvl = IO_WR && hit_lvl;
  wire wr_out = IO_WR && (IO_ADDR == irqv_pkg::OUT_VECTOR_OFFSET);
  wire serve_vme = latched ? latched_vme : vme_any;
  wire ext_ack = EXT_IACK_SEL && EXT_IACK_READ && requesting;

  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (rd_vec_start && serve_vme) begin
          next_state = IACK;
        end else if (rd_vec_start) begin
          next_state = ANSWER;
        end
      end
      IACK: begin
        if (VME_IACK_DONE) begin
          next_state = ANSWER;
        end
      end
      ANSWER: begin
        if (!IO_RD) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= IDLE;
      rd_vec_d <= 1'b0;
    end else begin
      state <= next_state;
      rd_vec_d <= rd_vec;
    end
  end

  // vector capture: bus data or local done byte
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fetched <= irqv_pkg::VECTOR_RESET;
    end else if (state == IACK && VME_IACK_DONE) begin
      fetched <= VME_IACK_DATA;
    end else if (state == IDLE && rd_vec_start && !serve_vme) begin
      fetched <= DONE_VECTOR;
    end
  end

  // latch of serviced interrupt; a new one only after eoi
  always_ff @(posedge CLK) begin
    if (RESET) begin
      latched <= 1'b0;
      latched_vme <= 1'b0;
      latched_level <= 3'h0;
    end else if (wr_eoi) begin
      latched <= 1'b0;
    end else if (!latched && (vme_any || done_ok)) begin
      latched <= 1'b1;
      latched_vme <= vme_any;
      latched_level <= vme_level;
    end
  end

  assign HOST_IRQ = latched && latched_vme;
  assign HOST_NMI_DONE = latched && !latched_vme && done_ok;
  assign VME_IACK_REQ = state == IACK;
  assign VME_IACK_LEVEL = latched ? latched_level : vme_level;
  assign IO_READY = (state == ANSWER) || (IO_RD && !hit_vec) || IO_WR;

  // level register: no reset (undefined on power-up), iack never alters it
  always_ff @(posedge CLK) begin
    if (wr_lvl) begin
      level_reg <= IO_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (wr_out) begin
      out_vector <= IO_WDATA;
    end
  end

  // only marks the level register as written; its contents stay unknown until then
  always_ff @(posedge CLK) begin
    if (RESET) begin
      level_known <= 1'b0;
    end else if (wr_lvl) begin
      level_known <= 1'b1;
    end
  end

  // requesting set by local request, released on acknowledge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      requesting <= 1'b0;
      done_event <= 1'b0;
      EXT_IACK_DATA <= 8'h00;
    end else begin
      // set wins over eoi so an acknowledge in the eoi cycle is not lost
      if (ext_ack && GROUP_MASK[irqv_pkg::DONE_ENABLE_POS]) begin
        done_event <= 1'b1;
      end else if (wr_eoi) begin
        done_event <= 1'b0;
      end
      EXT_IACK_DATA <= out_vector;
      if (LOCAL_REQUEST) begin
        requesting <= 1'b1;
      end else if (ext_ack) begin
        requesting <= 1'b0;
      end
    end
  end

  always_comb begin
    read_data = 8'h00;
    if (hit_vec) begin
      read_data = fetched;
    end else if (hit_lvl) begin
      read_data = level_reg;
    end else if (hit_line) begin
      read_data = {1'b0, irq_level};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      IO_RDATA <= 8'h00;
    end else begin
      IO_RDATA <= (state == IACK && VME_IACK_DONE) ? VME_IACK_DATA : read_data;
    end
  end

  property p_eoi_clears;
    @(posedge CLK) disable iff (RESET) wr_eoi |=> !latched;
  endproperty
  a_eoi_clears: assert property (p_eoi_clears) else $error("eoi left latch set");

  property p_vme_first;
    @(posedge CLK) disable iff (RESET)
      (!latched && !wr_eoi && vme_any && done_ok) |=> latched_vme;
  endproperty
  a_vme_first: assert property (p_vme_first) else $error("done served before bus");

  property p_iack_on_read;
    @(posedge CLK) disable iff (RESET)
      (state == IDLE && rd_vec_start && serve_vme) |=> VME_IACK_REQ;
  endproperty
  a_iack_on_read: assert property (p_iack_on_read) else $error("no iack on vector read");

  property p_done_no_cycle;
    @(posedge CLK) disable iff (RESET)
      (state == IDLE && rd_vec_start && !serve_vme) |=>
      !VME_IACK_REQ && fetched == $past(DONE_VECTOR);
  endproperty
  a_done_no_cycle: assert property (p_done_no_cycle) else $error("done vector wrong");

  property p_release;
    @(posedge CLK) disable iff (RESET) (ext_ack && !LOCAL_REQUEST) |=> VME_IRQ_OE == 7'h00;
  endproperty
  a_release: assert property (p_release) else $error("line held after ack");

  property p_done_raise;
    @(posedge CLK) disable iff (RESET)
      (ext_ack && GROUP_MASK[0]) |=> done_event;
  endproperty
  a_done_raise: assert property (p_done_raise) else $error("done not raised");

  property p_no_line_low_codes;
    @(posedge CLK) disable iff (RESET)
      (level_reg[2:0] < 3'h3) |-> VME_IRQ_OE == 7'h00;
  endproperty
  a_no_line_low_codes: assert property (p_no_line_low_codes)
    else $error("line on no-line code");

  property p_level_stable;
    @(posedge CLK) disable iff (RESET) (level_known && !wr_lvl) |=> $stable(level_reg);
  endproperty
  a_level_stable: assert property (p_level_stable) else $error("level register changed");

  property p_nmi_gate;
    @(posedge CLK) disable iff (RESET) HOST_NMI_DONE |-> GROUP_MASK[0];
  endproperty
  a_nmi_gate: assert property (p_nmi_gate) else $error("nmi without enable");

  property p_line_read;
    @(posedge CLK) disable iff (RESET)
      (IO_RD && hit_line) |=> IO_RDATA == {1'b0, $past(irq_level)};
  endproperty
  a_line_read: assert property (p_line_read) else $error("line state read wrong");

  property p_top_first;
    @(posedge CLK) disable iff (RESET) vme_any |-> (vme_active >> vme_level) == 7'h00;
  endproperty
  a_top_first: assert property (p_top_first) else $error("lower irq chosen first");

  c_vme_fetch: cover property (@(posedge CLK) disable iff (RESET)
    state == IACK ##[1:20] state == ANSWER);
  c_done_fetch: cover property (@(posedge CLK) disable iff (RESET)
    (state == IDLE && rd_vec_start && !serve_vme));
  c_ext_ack: cover property (@(posedge CLK) disable iff (RESET) ext_ack);
  c_eoi: cover property (@(posedge CLK) disable iff (RESET) latched ##1 wr_eoi);
endmodule : irqv_top

// >>> irqv_pkg.sv
// shared constants for the vme interrupt vector and interrupter block
package irqv_pkg;
  localparam logic [9:0] VECTOR_OFFSET = 10'h14d;
  localparam logic [9:0] EOI_OFFSET = 10'h14d;
  localparam logic [9:0] LEVEL_OFFSET = 10'h14e;
  localparam logic [9:0] LINE_STATE_OFFSET = 10'h14f;
  localparam logic [9:0] OUT_VECTOR_OFFSET = 10'h14f;
  localparam int FLAG_POS = 7;
  localparam int LEVEL_MSB = 2;
  localparam logic [2:0] FIRST_LEVEL_CODE = 3'h3;
  localparam int DONE_ENABLE_POS = 0;
  localparam int VME_ENABLE_POS = 2;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  localparam int CLK_MHZ = 100;
  localparam int RORA_WAIT_US = 2;
  localparam int RORA_WAIT_CYCLES = RORA_WAIT_US * CLK_MHZ;
  localparam logic [2:0] IACK_TIMEOUT_CYCLES = 3'h7;
endpackage : irqv_pkg

// >>> irqv_sync.sv
// three-stage synchroniser for the seven irq lines
`timescale 1ns/1ns
module irqv_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] async_in,
  output logic [6:0] stable
);
  logic [6:0] s1;
  logic [6:0] s2;
  logic [6:0] s3;
  // idle level of the bus lines is high (released)
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= 7'h7f;
      s2 <= 7'h7f;
      s3 <= 7'h7f;
      stable <= 7'h7f;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable(stable, s2, s3);
    end
  end
  function automatic logic [6:0] next_stable(input logic [6:0] cur, input logic [6:0] a,
                                             input logic [6:0] b);
    logic [6:0] r;
    r = cur;
    for (int i = 0; i < 7; i++) begin
      if (a[i] == b[i]) begin
        r[i] = a[i];
      end
    end
    return r;
  endfunction : next_stable
endmodule : irqv_sync

// >>> irqv_level_decode.sv
// level code to one-hot outgoing irq line decode
`timescale 1ns/1ns
module irqv_level_decode (
  input wire logic [2:0] level_code,
  input wire logic request,
  output logic [6:0] line_drive
);
  // bit n drives irq(n+1); codes below three drive nothing
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_line
      assign line_drive[g] = request && (level_code >= irqv_pkg::FIRST_LEVEL_CODE)
                             && (level_code == 3'(g + 1));
    end
  endgenerate
endmodule : irqv_level_decode

// >>> vme_iack_responder.sv
// far-side vme interrupter that answers the block's iack fetch
`timescale 1ns/1ns
module vme_iack_responder (
  input wire logic clk,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic [3:0] wait_cycles,
  output logic iack_done,
  output logic [7:0] iack_data,
  output logic [2:0] seen_level
);
  logic [3:0] count = 4'h0;
  logic [7:0] last = 8'h00;
  initial begin
    iack_done = 1'b0;
    iack_data = 8'h00;
    seen_level = 3'h0;
  end
  // data is valid only in the done cycle; otherwise show its inverse
  always @(posedge clk) begin
    iack_done <= 1'b0;
    iack_data <= ~last;
    if (iack_req && !iack_done) begin
      if (count == wait_cycles) begin
        iack_done <= 1'b1;
        iack_data <= {5'h1a, iack_level};
        last <= {5'h1a, iack_level};
        seen_level <= iack_level;
        count <= 4'h0;
      end else begin
        count <= count + 4'h1;
      end
    end else begin
      count <= 4'h0;
    end
  end
endmodule : vme_iack_responder

// >>> tb_irqv_top.sv
// self-checking bench for the vme interrupt vector and interrupter block
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_irqv_top;
  logic CLK = 1'b0, RESET = 1'b1, IO_RD = 1'b0, IO_WR = 1'b0, DONE_PENDING = 1'b0;
  logic LOCAL_REQUEST = 1'b0, EXT_IACK_SEL = 1'b0, EXT_IACK_READ = 1'b0;
  logic [9:0] IO_ADDR = 10'h000;
  logic [7:0] IO_WDATA = 8'h00, GROUP_MASK = 8'h00, DONE_VECTOR = 8'h00, d;
  logic [6:0] IRQ_MASK = 7'h00, ext_n = 7'h7f;
  logic [3:0] slow = 4'h0;
  logic [2:0] seen;
  logic saw_iack = 1'b0;
  wire logic [7:0] IO_RDATA, VME_IACK_DATA, EXT_IACK_DATA;
  wire logic [6:0] VME_IRQ_OE;
  wire logic [2:0] VME_IACK_LEVEL;
  wire logic IO_READY, HOST_IRQ, HOST_NMI_DONE, VME_IACK_REQ, VME_IACK_DONE;
  // the bus line is low when anyone drives it
  wire logic [6:0] irq_n = ext_n & ~VME_IRQ_OE;
  int n_errors = 0, cmp_count = 0;
  always #5 CLK = ~CLK;
  always @(posedge CLK) if (VME_IACK_REQ === 1'b1) saw_iack <= 1'b1;
  irqv_top dut (.CLK(CLK), .RESET(RESET), .IO_ADDR(IO_ADDR), .IO_RD(IO_RD), .IO_WR(IO_WR),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_READY(IO_READY), .IRQ_MASK(IRQ_MASK),
    .GROUP_MASK(GROUP_MASK), .DONE_VECTOR(DONE_VECTOR), .DONE_PENDING(DONE_PENDING),
    .LOCAL_REQUEST(LOCAL_REQUEST), .VME_IRQ_N(irq_n), .VME_IRQ_OE(VME_IRQ_OE),
    .HOST_IRQ(HOST_IRQ), .HOST_NMI_DONE(HOST_NMI_DONE), .VME_IACK_REQ(VME_IACK_REQ),
    .VME_IACK_LEVEL(VME_IACK_LEVEL), .VME_IACK_DONE(VME_IACK_DONE),
    .VME_IACK_DATA(VME_IACK_DATA), .EXT_IACK_SEL(EXT_IACK_SEL),
    .EXT_IACK_READ(EXT_IACK_READ), .EXT_IACK_DATA(EXT_IACK_DATA));
  vme_iack_responder far (.clk(CLK), .iack_req(VME_IACK_REQ), .iack_level(VME_IACK_LEVEL),
    .wait_cycles(slow), .iack_done(VME_IACK_DONE), .iack_data(VME_IACK_DATA),
    .seen_level(seen));
  task automatic cycles(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cycles
  task automatic io_write(input logic [9:0] a, input logic [7:0] v);
    IO_ADDR = a;
    IO_WDATA = v;
    IO_WR = 1'b1;
    cycles(1);
    IO_WR = 1'b0;
    cycles(1);
  endtask : io_write
  // strobe held until ready is sampled at a rising edge; data taken just after it
  task automatic io_read(input logic [9:0] a, output logic [7:0] v);
    int n;
    n = 0;
    IO_ADDR = a;
    IO_RD = 1'b1;
    @(posedge CLK);
    while (IO_READY !== 1'b1 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 50) n_errors++;
    #1;
    IO_RD = 1'b0;
    v = IO_RDATA;
    cycles(1);
  endtask : io_read
  task automatic t_level;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], 4'h0, i[2:0]};
      GROUP_MASK = {7'h00, i[1]};
      io_write(irqv_pkg::LEVEL_OFFSET, v);
      io_write(irqv_pkg::OUT_VECTOR_OFFSET, 8'h40 + 8'(i));
      io_read(irqv_pkg::LEVEL_OFFSET, d);
      `CHK(d, v)
      LOCAL_REQUEST = 1'b1;
      cycles(1);
      LOCAL_REQUEST = 1'b0;
      cycles(2);
      `CHK(VME_IRQ_OE, (i >= 3) ? 7'h01 << (i - 1) : 7'h00)
      EXT_IACK_SEL = 1'b1;
      EXT_IACK_READ = 1'b1;
      cycles(1);
      `CHK(EXT_IACK_DATA, 8'h40 + 8'(i))
      EXT_IACK_SEL = 1'b0;
      EXT_IACK_READ = 1'b0;
      cycles(3);
      `CHK(VME_IRQ_OE, 7'h00)
      if (i >= 3) `CHK(HOST_NMI_DONE, i[1])
      io_read(irqv_pkg::LEVEL_OFFSET, d);
      `CHK(d, v)
      io_write(irqv_pkg::EOI_OFFSET, 8'(i));
    end
    GROUP_MASK = 8'h00;
  endtask : t_level
  task automatic t_lines;
    ext_n = 7'h2d;
    cycles(6);
    io_read(irqv_pkg::LINE_STATE_OFFSET, d);
    `CHK(d, 8'h2d)
    ext_n = 7'h7f;
    io_read(10'h150, d);
    `CHK(d, 8'h00)
  endtask : t_lines
  task automatic t_vector;
    IRQ_MASK = 7'h7f;
    DONE_PENDING = 1'b1;
    ext_n = ~7'h12;
    cycles(6);
    // both sources become visible in the same cycle
    GROUP_MASK = 8'h05;
    cycles(2);
    `CHK(HOST_IRQ, 1'b1)
    `CHK(HOST_NMI_DONE, 1'b0)
    io_read(irqv_pkg::VECTOR_OFFSET, d);
    `CHK(d, 8'hd5)
    `CHK(seen, 3'h5)
    ext_n = 7'h7f;
    DONE_PENDING = 1'b0;
    cycles(irqv_pkg::RORA_WAIT_CYCLES);
    io_write(irqv_pkg::EOI_OFFSET, 8'ha5);
    `CHK(HOST_IRQ, 1'b0)
    slow = 4'h9;
    ext_n = ~7'h40;
    cycles(6);
    `CHK(HOST_IRQ, 1'b1)
    io_read(irqv_pkg::VECTOR_OFFSET, d);
    `CHK(d, 8'hd7)
    ext_n = 7'h7f;
    cycles(irqv_pkg::RORA_WAIT_CYCLES);
    io_write(irqv_pkg::EOI_OFFSET, 8'h00);
  endtask : t_vector
  task automatic t_done;
    DONE_VECTOR = 8'hc3;
    DONE_PENDING = 1'b1;
    cycles(6);
    `CHK(HOST_NMI_DONE, 1'b1)
    saw_iack = 1'b0;
    io_read(irqv_pkg::VECTOR_OFFSET, d);
    `CHK(d, 8'hc3)
    `CHK(saw_iack, 1'b0)
    DONE_PENDING = 1'b0;
    io_write(irqv_pkg::EOI_OFFSET, 8'hff);
  endtask : t_done
  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // the whole sequence needs well under 5000 cycles
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    cycles(12);
    RESET = 1'b0;
    cycles(5);
    t_level();
    t_lines();
    t_vector();
    t_done();
    end_of_test();
  end
endmodule : tb_irqv_top
